// ---- logic/nidab_builder.v ----
// Notes on behaviour
// - Word 0 is 02h then three zeros.
// - Common block from word 2, specific follows.
// - Format 00h returns common block only.
// - 01h..DEh: protocol specific data, common optional.
// - DFh: common block plus topology data.
// - E0h..FFh: vendor data, common optional.
// - Common length 16 when block present.
// - Common length zero when block absent.
// - Word 1 bits 15-14 carry phy type.
// - Phy 00 none, 01 FC, 10 Ethernet.
// - Word 1 bits 13-8 are reserved zero.
// - Specific length is byte count, multiple four.
// - Specific length within 0 to 252.
// - Common words 0-1 carry port name.
// - Common words 2-3 carry node name.
// - Layout chosen by format value.
// - Reject when refused, accept only when accepted.
// - Unsupported: reject, or common block only.
`timescale 1ns/1ns
`include "nidab_defs.vh"
module nidab_builder #(
	parameter SPEC_AW = 6
) (
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	input wire req_valid_in,
	input wire [7:0] req_format_in,
	input wire rnid_enable_in,
	input wire fmt_supported_in,
	input wire unsup_common_only_in,
	input wire ulp_common_in,
	input wire vend_common_in,
	input wire [1:0] phy_type_in,
	input wire [63:0] port_name_in,
	input wire [63:0] node_name_in,
	input wire [7:0] spec_len_in,
	output reg [SPEC_AW-1:0] spec_addr_out,
	input wire [31:0] spec_word_in,
	output reg busy_out,
	output reg rjt_valid_out,
	output reg rjt_unsup_cmd_out,
	output reg rjt_no_data_out,
	output reg acc_valid_out,
	input wire acc_ready_in,
	output reg [31:0] acc_word_out,
	output reg acc_last_out
);
	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam ST_IDLE = 5'b00001;
	localparam ST_W0 = 5'b00010;
	localparam ST_W1 = 5'b00100;
	localparam ST_COM = 5'b01000;
	localparam ST_SPEC = 5'b10000;

	reg [4:0] state_r;
	reg [7:0] fmt_r;
	reg com_r;
	reg [7:0] slen_r;
	reg [1:0] phy_r;
	reg [2:0] cidx_r;
	reg [SPEC_AW-1:0] sidx_r;
	reg [31:0] word;
	reg wlast;
	reg push;
	reg want_com;
	reg take_spec;
	reg [7:0] slen_clip;
	wire f_ready;
	wire f_valid;
	wire [32:0] f_data;
	wire [SPEC_AW-1:0] spec_words;

	// ---------------------------------------------------------------
	// Request decode
	// ---------------------------------------------------------------
	// Decide which blocks the reply holds for the requested format.
	always @* begin
		want_com = 1'b1;
		take_spec = 1'b0;
		if (req_format_in == `NIDAB_FMT_COMMON) begin
			want_com = 1'b1;
			take_spec = 1'b0;
		end else if (!fmt_supported_in) begin
			want_com = 1'b1;
			take_spec = 1'b0;
		end else if (req_format_in == `NIDAB_FMT_TOPO) begin
			want_com = 1'b1;
			take_spec = 1'b1;
		end else if (req_format_in <= `NIDAB_FMT_ULP_HI) begin
			want_com = ulp_common_in;
			take_spec = 1'b1;
		end else begin
			want_com = vend_common_in;
			take_spec = 1'b1;
		end
		slen_clip = {spec_len_in[7:2], `NIDAB_LEN_ALIGN};
		if (!take_spec) begin
			slen_clip = `NIDAB_ZERO_BYTE;
		end else if (slen_clip > `NIDAB_SPEC_MAX) begin
			slen_clip = `NIDAB_SPEC_MAX;
		end
	end

	assign spec_words = slen_r[SPEC_AW+1:2];

	// ---------------------------------------------------------------
	// Payload word select
	// ---------------------------------------------------------------
	// ascending word order
	always @* begin
		word = 32'h00000000;
		wlast = 1'b0;
		push = 1'b0;
		case (state_r)
		ST_W0: begin
			push = 1'b1;
			word = {`NIDAB_ACC_CODE, `NIDAB_ZERO_BYTE,
				`NIDAB_ZERO_BYTE, `NIDAB_ZERO_BYTE};
		end
		ST_W1: begin
			push = 1'b1;
			word = {fmt_r,
				com_r ? `NIDAB_COMMON_LEN : `NIDAB_ZERO_BYTE,
				phy_r, `NIDAB_RSVD6, slen_r};
			wlast = ~com_r & (slen_r == `NIDAB_ZERO_BYTE);
		end
		ST_COM: begin
			push = 1'b1;
			case (cidx_r[1:0])
			2'h0: begin
				word = port_name_in[63:32];
			end
			2'h1: begin
				word = port_name_in[31:0];
			end
			2'h2: begin
				word = node_name_in[63:32];
			end
			default: begin
				word = node_name_in[31:0];
			end
			endcase
			wlast = (cidx_r == `NIDAB_COMMON_WORDS - 3'h1) &
				(slen_r == `NIDAB_ZERO_BYTE);
		end
		ST_SPEC: begin
			push = 1'b1;
			word = spec_word_in;
			wlast = (sidx_r == spec_words - 1'b1);
		end
		default: begin
			push = 1'b0;
		end
		endcase
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// The FIFO ready stalls every step, so a slow sink pauses the reply.
	always @(posedge mclk_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
			fmt_r <= `NIDAB_ZERO_BYTE;
			com_r <= 1'b0;
			slen_r <= `NIDAB_ZERO_BYTE;
			phy_r <= `NIDAB_PHY_NONE;
			cidx_r <= 3'h0;
			sidx_r <= {SPEC_AW{1'b0}};
			spec_addr_out <= {SPEC_AW{1'b0}};
			busy_out <= 1'b0;
			rjt_valid_out <= 1'b0;
			rjt_unsup_cmd_out <= 1'b0;
			rjt_no_data_out <= 1'b0;
		end else if (ce_in) begin
			rjt_valid_out <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				cidx_r <= 3'h0;
				sidx_r <= {SPEC_AW{1'b0}};
				spec_addr_out <= {SPEC_AW{1'b0}};
				if (req_valid_in) begin
					if (!rnid_enable_in) begin
						rjt_valid_out <= 1'b1;
						rjt_unsup_cmd_out <= 1'b1;
						rjt_no_data_out <= 1'b0;
					end else if (!fmt_supported_in &&
						req_format_in != `NIDAB_FMT_COMMON &&
						!unsup_common_only_in) begin
						rjt_valid_out <= 1'b1;
						rjt_unsup_cmd_out <= 1'b0;
						rjt_no_data_out <= 1'b1;
					end else begin
						state_r <= ST_W0;
						busy_out <= 1'b1;
						fmt_r <= req_format_in;
						com_r <= want_com;
						slen_r <= slen_clip;
						phy_r <= (phy_type_in == `NIDAB_PHY_RSVD) ?
							`NIDAB_PHY_NONE : phy_type_in;
					end
				end
			end
			ST_W0: begin
				if (f_ready) begin
					state_r <= ST_W1;
				end
			end
			ST_W1: begin
				if (f_ready) begin
					if (com_r) begin
						state_r <= ST_COM;
					end else if (slen_r != `NIDAB_ZERO_BYTE) begin
						state_r <= ST_SPEC;
					end else begin
						state_r <= ST_IDLE;
						busy_out <= 1'b0;
					end
				end
			end
			ST_COM: begin
				if (f_ready) begin
					cidx_r <= cidx_r + 3'h1;
					if (cidx_r == `NIDAB_COMMON_WORDS - 3'h1) begin
						if (slen_r != `NIDAB_ZERO_BYTE) begin
							state_r <= ST_SPEC;
						end else begin
							state_r <= ST_IDLE;
							busy_out <= 1'b0;
						end
					end
				end
			end
			ST_SPEC: begin
				if (f_ready) begin
					sidx_r <= sidx_r + 1'b1;
					spec_addr_out <= sidx_r + 1'b1;
					if (wlast) begin
						state_r <= ST_IDLE;
						busy_out <= 1'b0;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Output buffer and registered stream port
	// ---------------------------------------------------------------
	nidab_fifo #(
		.WIDTH(33),
		.DEPTH(`NIDAB_WORD_DEPTH),
		.AW(2)
	) u_fifo (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.in_valid_in(push),
		.in_ready_out(f_ready),
		.in_data_in({wlast, word}),
		.out_valid_out(f_valid),
		.out_ready_in(~acc_valid_out | acc_ready_in),
		.out_data_out(f_data)
	);

	// Output stage registers the FIFO head so outputs come from flops.
	always @(posedge mclk_in) begin
		if (rst_in) begin
			acc_valid_out <= 1'b0;
			acc_word_out <= 32'h00000000;
			acc_last_out <= 1'b0;
		end else if (ce_in) begin
			if (~acc_valid_out | acc_ready_in) begin
				acc_valid_out <= f_valid;
				acc_word_out <= f_data[31:0];
				acc_last_out <= f_data[32];
			end
		end
	end
endmodule

// ---- logic/nidab_defs.vh ----
`ifndef NIDAB_DEFS_VH
`define NIDAB_DEFS_VH
// ---------------------------------------------------------------
// Payload constants
// ---------------------------------------------------------------
`define NIDAB_ACC_CODE 8'h02
`define NIDAB_ZERO_BYTE 8'h00
`define NIDAB_FMT_COMMON 8'h00
`define NIDAB_FMT_ULP_LO 8'h01
`define NIDAB_FMT_ULP_HI 8'hde
`define NIDAB_FMT_TOPO 8'hdf
`define NIDAB_FMT_VEND_LO 8'he0
`define NIDAB_COMMON_LEN 8'h10
`define NIDAB_COMMON_WORDS 3'h4
`define NIDAB_SPEC_MAX 8'hfc
`define NIDAB_PHY_NONE 2'h0
`define NIDAB_PHY_FC 2'h1
`define NIDAB_PHY_ETH 2'h2
`define NIDAB_PHY_RSVD 2'h3
`define NIDAB_RSVD6 6'h00
`define NIDAB_LEN_ALIGN 2'h0
`define NIDAB_WORD_DEPTH 4
`endif

// ---- logic/nidab_fifo.v ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module nidab_fifo #(
	parameter WIDTH = 33,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_out = (cnt_r != DEPTH[AW:0]);
	assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
	assign out_data_out = mem[rp_r];
	assign push = ce_in & in_valid_in & in_ready_out;
	assign pop = ce_in & out_valid_out & out_ready_in;

	// Storage has no reset; only pointers and count carry control state.
	always @(posedge mclk_in) begin
		if (push) begin
			mem[wp_r] <= in_data_in;
		end
	end

	// Pointers wrap; DEPTH is expected to be a power of two.
	always @(posedge mclk_in) begin
		if (rst_in) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ---- bench/nidab_checker.sv ----
`timescale 1ns/1ns
// -----------------------------------
// Reply stream checker
// -----------------------------------
module nidab_checker (
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	input wire req_valid_in,
	input wire busy_out,
	input wire rjt_valid_out,
	input wire rjt_unsup_cmd_out,
	input wire rjt_no_data_out,
	input wire acc_valid_out,
	input wire acc_ready_in,
	input wire [31:0] acc_word_out,
	input wire acc_last_out
);
	reg [7:0] idx_r;
	// A word only moves on an enabled edge.
	wire hs = acc_valid_out && acc_ready_in && ce_in;
	wire [31:0] w = acc_word_out;
	wire w1 = acc_valid_out && idx_r == 8'h01;
	// Word index; it restarts after the last word of each reply.
	always @(posedge mclk_in) begin
		if (rst_in || (hs && acc_last_out))
			idx_r <= 8'h00;
		else if (hs)
			idx_r <= idx_r + 8'h01;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_word0_code: assert property (
		acc_valid_out && idx_r == 8'h00 |-> w == 32'h02000000)
		else $error("word 0 wrong");
	a_phy_code: assert property (w1 |-> w[15:14] != 2'h3)
		else $error("phy code reserved");
	a_rsvd_zero: assert property (w1 |-> w[13:8] == 6'h00)
		else $error("reserved bits set");
	a_spec_len: assert property (
		w1 |-> w[1:0] == 2'h0 && w[7:0] <= 8'hfc)
		else $error("specific length bad");
	a_com_len: assert property (
		w1 |-> w[23:16] == 8'h00 || w[23:16] == 8'h10)
		else $error("common length bad");
	a_fmt_zero: assert property (
		w1 && w[31:24] == 8'h00 |-> w[23:16] == 8'h10 && w[7:0] == 8'h00)
		else $error("format 0 reply bad");
	a_topo_common: assert property (
		w1 && w[31:24] == 8'hdf |-> w[23:16] == 8'h10)
		else $error("topology reply lacks common");
	a_word_hold: assert property (
		acc_valid_out && !acc_ready_in |=>
		acc_valid_out && $stable(w) && $stable(acc_last_out))
		else $error("word not held");
	a_rjt_pulse: assert property (
		rjt_valid_out && ce_in |=> !rjt_valid_out)
		else $error("reject longer than a cycle");
	a_rjt_reason: assert property (
		rjt_valid_out |-> rjt_unsup_cmd_out ^ rjt_no_data_out)
		else $error("reject reason bad");
	a_req_answer: assert property (
		req_valid_in && !busy_out && ce_in |=> busy_out || rjt_valid_out)
		else $error("request not answered");
	c_reject: cover property (rjt_valid_out);
	c_last: cover property (hs && acc_last_out);
	c_stall: cover property (acc_valid_out && !acc_ready_in);
	c_freeze: cover property (busy_out && !ce_in);
endmodule

// ---- bench/nidab_req_sink.sv ----
`timescale 1ns/1ns
// -----------------------------------
// Requesting port, receive side
// -----------------------------------
module nidab_req_sink (
	input wire mclk_in,
	input wire rst_in,
	output reg acc_ready_out
);
	integer seed_r;
	initial begin
		seed_r = 32'hc2f3;
	end
	// identity use only
	// Words are only taken; random stalls make the builder hold them.
	always @(posedge mclk_in) begin
		acc_ready_out <= !rst_in && ($random(seed_r) % 4 != 0);
	end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	reg mclk_in = 1'b0;
	reg rst_in = 1'b1;
	reg req_valid_in = 1'b0;
	reg [7:0] req_format_in = 8'h00;
	reg rnid_enable_in = 1'b1;
	reg fmt_supported_in = 1'b1;
	reg unsup_common_only_in = 1'b0;
	reg ulp_common_in = 1'b0;
	reg vend_common_in = 1'b0;
	reg [1:0] phy_type_in = 2'h0;
	reg [63:0] port_name_in = 64'h0;
	reg [63:0] node_name_in = 64'h0;
	reg [7:0] spec_len_in = 8'h00;
	wire [5:0] spec_addr_out;
	wire [31:0] spec_word_in;
	wire busy_out, rjt_valid_out, rjt_unsup_cmd_out, rjt_no_data_out;
	wire acc_valid_out, acc_ready_in, acc_last_out;
	wire [31:0] acc_word_out;
	integer seed, mismatches, checked, i, n, t, k, exp_n;
	reg [31:0] exp_q [0:70];
	reg [1:0] kind;
	reg rjt_cmd;
	reg ce_in = 1'b1;
	integer rjt_cnt = 0, rjt_base, ce_seed = 32'hc2f3;
	reg [7:0] fmts [0:7];
	always #20 mclk_in = ~mclk_in;
	// Specific data source: a pattern that differs per word.
	assign spec_word_in = 32'h5ac30000 ^ {26'h0, spec_addr_out};
	nidab_builder #(.SPEC_AW(6)) uut (.mclk_in, .rst_in, .ce_in,
		.req_valid_in, .req_format_in, .rnid_enable_in, .fmt_supported_in,
		.unsup_common_only_in, .ulp_common_in, .vend_common_in,
		.phy_type_in, .port_name_in, .node_name_in, .spec_len_in,
		.spec_addr_out, .spec_word_in, .busy_out, .rjt_valid_out,
		.rjt_unsup_cmd_out, .rjt_no_data_out, .acc_valid_out,
		.acc_ready_in, .acc_word_out, .acc_last_out);
	nidab_req_sink sink (.mclk_in, .rst_in, .acc_ready_out(acc_ready_in));
	// Rejects are one cycle long, so a monitor counts them.
	always @(negedge mclk_in) begin
		if (rjt_valid_out) begin
			rjt_cnt = rjt_cnt + 1;
			rjt_cmd = rjt_unsup_cmd_out;
		end
	end
	// Clock enable drops at random only while a reply is in flight.
	// Requests and reject pulses then always meet an enabled edge.
	always @(posedge mclk_in) begin
		ce_in <= !busy_out || ($random(ce_seed) % 8 != 0);
	end
	task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checked %0d mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// -----------------------------------
	// Expected reply from the present settings
	// -----------------------------------
	function void plan;
		reg com;
		reg [7:0] sl;
		begin
			com = 1'b1;
			sl = {spec_len_in[7:2], 2'h0};
			kind = 2'd0;
			if (!rnid_enable_in)
				kind = 2'd1;
			else if (req_format_in == 8'h00)
				sl = 8'h00;
			else if (!fmt_supported_in) begin
				kind = unsup_common_only_in ? 2'd0 : 2'd2;
				sl = 8'h00;
			end else if (req_format_in < 8'hdf)
				com = ulp_common_in;
			else if (req_format_in > 8'hdf)
				com = vend_common_in;
			exp_q[0] = 32'h02000000;
			exp_q[1] = {req_format_in, com ? 8'h10 : 8'h00,
				phy_type_in == 2'h3 ? 2'h0 : phy_type_in, 6'h00, sl};
			exp_n = com ? 6 : 2;
			{exp_q[2], exp_q[3]} = port_name_in;
			{exp_q[4], exp_q[5]} = node_name_in;
			for (i = 0; i < sl / 4; i = i + 1)
				exp_q[exp_n + i] = 32'h5ac30000 ^ i;
			exp_n = exp_n + sl / 4;
		end
	endfunction
	task run_one(input dup);
		begin
			rjt_base = rjt_cnt;
			@(posedge mclk_in);
			req_valid_in <= 1'b1;
			plan();
			@(posedge mclk_in);
			req_valid_in <= dup && kind == 2'd0;
			@(posedge mclk_in);
			req_valid_in <= 1'b0;
			n = 0;
			t = 0;
			while (kind == 2'd0 && n < exp_n && t < 400) begin
				@(negedge mclk_in);
				t = t + 1;
				if (acc_valid_out && acc_ready_in && ce_in) begin
					check("word", acc_word_out, exp_q[n]);
					check("last", acc_last_out, n == exp_n - 1);
					n = n + 1;
				end
			end
			check("count", n, kind == 2'd0 ? exp_n : 0);
			check("reject", rjt_cnt - rjt_base, kind != 2'd0);
			if (kind != 2'd0)
				check("why", rjt_cmd, kind == 2'd1);
			t = 0;
			while (busy_out && t < 100) begin
				@(negedge mclk_in);
				t = t + 1;
			end
		end
	endtask
	initial begin
		seed = 32'hc2f3;
		mismatches = 0;
		checked = 0;
		{fmts[0], fmts[1], fmts[2], fmts[3]} = 32'h00017fde;
		{fmts[4], fmts[5], fmts[6], fmts[7]} = 32'hdfe0ff00;
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Table of corner formats first, then random requests.
		for (k = 0; k < 60; k = k + 1) begin
			@(posedge mclk_in);
			req_format_in <= k < 8 ? fmts[k] : $random(seed);
			rnid_enable_in <= k != 7 && (k < 8 || $random(seed) % 8 != 0);
			fmt_supported_in <= k < 8 || $random(seed) % 4 != 0;
			unsup_common_only_in <= $random(seed);
			ulp_common_in <= $random(seed);
			vend_common_in <= $random(seed);
			phy_type_in <= k < 4 ? k : $random(seed);
			port_name_in <= {$random(seed), $random(seed)};
			node_name_in <= {$random(seed), $random(seed)};
			spec_len_in <= k == 4 ? 8'hff : k == 1 ? 8'h00 : $random(seed);
			run_one(k % 3 == 0);
		end
		report_and_stop;
	end
	initial begin
		#800000;
		mismatches = mismatches + 1;
		report_and_stop;
	end
endmodule
bind nidab_builder nidab_checker chk (.mclk_in, .rst_in, .ce_in,
	.req_valid_in,
	.busy_out, .rjt_valid_out, .rjt_unsup_cmd_out, .rjt_no_data_out,
	.acc_valid_out, .acc_ready_in, .acc_word_out, .acc_last_out);
